// file: common/ctso_pkg.sv
// Behaviour
// - Alarm A active on any unmasked A bit
// - Alarm B activates on any unmasked B bit
// - Alarm B releases only when B bits clear
// - Alarm C activates on any unmasked C bit
// - Alarm C releases only when C bits clear
// - Status bits 7 to 5 read zero
// - Set bit when reading at or above limit
// - Clear bit below limit minus hysteresis
// - Bit 4..1 remote 4..1, bit 0 local
// - Local bit uses the one local limit
// - Register A uses remote 1/2 first limits
// - Register B uses remote 1/2 second limits
// - Register C also uses second limits
// - Remote 3/4 each use their own one limit everywhere
// - Mask bit blocks channel; resets 19,00,07
// - Common status flags any-bit-set per register
package ctso_pkg;
	localparam int CH_N = 5;
	localparam int REG_N = 3;
	localparam int DATA_W = 8;
	localparam int CH_LOCAL = 0;
	localparam int CH_REM1 = 1;
	localparam int CH_REM2 = 2;
	localparam int CH_REM3 = 3;
	localparam int CH_REM4 = 4;
	localparam int REG_A = 0;
	localparam int REG_B = 1;
	localparam int REG_C = 2;
	localparam logic [7:0] ADDR_COMMON = 8'h02;
	localparam logic [7:0] ADDR_STAT_A = 8'h08;
	localparam logic [7:0] ADDR_STAT_B = 8'h09;
	localparam logic [7:0] ADDR_STAT_C = 8'h0a;
	localparam logic [7:0] ADDR_MASK_A = 8'h0c;
	localparam logic [7:0] ADDR_MASK_B = 8'h0d;
	localparam logic [7:0] ADDR_MASK_C = 8'h0e;
	localparam logic [4:0] MASK_A_RST = 5'h19;
	localparam logic [4:0] MASK_B_RST = 5'h00;
	localparam logic [4:0] MASK_C_RST = 5'h07;
	localparam int FLAG_A_POS = 1;
	localparam int FLAG_B_POS = 2;
	localparam int FLAG_C_POS = 3;
endpackage : ctso_pkg

// file: rtl/ctso_crit_status.sv
`timescale 1ns/1ps
module ctso_crit_status #(
	parameter int TEMP_W = 11
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [ctso_pkg::CH_N-1:0] result_valid_in,
	input wire logic signed [TEMP_W-1:0] local_temp_in,
	input wire logic signed [TEMP_W-1:0] rem1_temp_in,
	input wire logic signed [TEMP_W-1:0] rem2_temp_in,
	input wire logic signed [TEMP_W-1:0] rem3_temp_in,
	input wire logic signed [TEMP_W-1:0] rem4_temp_in,
	input wire logic signed [TEMP_W-1:0] local_limit_in,
	input wire logic signed [TEMP_W-1:0] rem1_limit_a_in,
	input wire logic signed [TEMP_W-1:0] rem1_limit_b_in,
	input wire logic signed [TEMP_W-1:0] rem2_limit_a_in,
	input wire logic signed [TEMP_W-1:0] rem2_limit_b_in,
	input wire logic signed [TEMP_W-1:0] rem3_limit_in,
	input wire logic signed [TEMP_W-1:0] rem4_limit_in,
	input wire logic [TEMP_W-1:0] hyst_in,
	input wire logic [7:0] cmd_in,
	input wire logic rd_en_in,
	input wire logic wr_en_in,
	input wire logic [ctso_pkg::DATA_W-1:0] wr_data_in,
	output logic [ctso_pkg::DATA_W-1:0] rd_data_out,
	output logic alarm_out_a_n_out,
	output logic alarm_out_b_n_out,
	output logic alarm_out_c_n_out
);
	localparam int CH_N = ctso_pkg::CH_N;
	localparam int REG_N = ctso_pkg::REG_N;
	localparam int EXT_W = TEMP_W + 2;

	////////////////////////////////////////////////////////////////////////////////
	// Channel readings and limit selection

	logic signed [TEMP_W-1:0] temp_w [CH_N];
	logic signed [TEMP_W-1:0] lim_w [REG_N][CH_N];
	logic [REG_N-1:0][CH_N-1:0] status_q;
	logic [REG_N-1:0][CH_N-1:0] status_d;
	logic [REG_N-1:0][CH_N-1:0] mask_q;
	logic [REG_N-1:0][CH_N-1:0] mask_d;
	logic [REG_N-1:0] alarm_q;
	logic [REG_N-1:0] alarm_d;
	logic [ctso_pkg::DATA_W-1:0] rd_data_d;

	assign temp_w[ctso_pkg::CH_LOCAL] = local_temp_in;
	assign temp_w[ctso_pkg::CH_REM1] = rem1_temp_in;
	assign temp_w[ctso_pkg::CH_REM2] = rem2_temp_in;
	assign temp_w[ctso_pkg::CH_REM3] = rem3_temp_in;
	assign temp_w[ctso_pkg::CH_REM4] = rem4_temp_in;

	genvar r, c;
	generate
		for (r = 0; r < REG_N; r++) begin : g_lim
			assign lim_w[r][ctso_pkg::CH_LOCAL] = local_limit_in;
			// Register A takes first-level limits, B and C both take second-level
			assign lim_w[r][ctso_pkg::CH_REM1] = (r == ctso_pkg::REG_A) ? rem1_limit_a_in : rem1_limit_b_in;
			assign lim_w[r][ctso_pkg::CH_REM2] = (r == ctso_pkg::REG_A) ? rem2_limit_a_in : rem2_limit_b_in;
			assign lim_w[r][ctso_pkg::CH_REM3] = rem3_limit_in;
			assign lim_w[r][ctso_pkg::CH_REM4] = rem4_limit_in;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Hysteresis comparators, one per register bit

	generate
		for (r = 0; r < REG_N; r++) begin : g_reg
			for (c = 0; c < CH_N; c++) begin : g_ch
				logic signed [EXT_W-1:0] temp_x;
				logic signed [EXT_W-1:0] lim_x;
				logic signed [EXT_W-1:0] clr_lvl;
				logic at_limit;
				logic below_band;
				// Two guard bits keep limit minus hysteresis from wrapping
				assign temp_x = {{2{temp_w[c][TEMP_W-1]}}, temp_w[c]};
				assign lim_x = {{2{lim_w[r][c][TEMP_W-1]}}, lim_w[r][c]};
				assign clr_lvl = lim_x - $signed({2'b00, hyst_in});
				assign at_limit = temp_x >= lim_x;
				assign below_band = temp_x < clr_lvl;
				// Bit c of each register is channel c
				assign status_d[r][c] = !result_valid_in[c] ? status_q[r][c] :
					at_limit ? 1'b1 :
					below_band ? 1'b0 : status_q[r][c];
			end
			// Asserts on unmasked bits, holds until every bit has cleared
			assign alarm_d[r] = (|(status_d[r] & ~mask_d[r])) | (alarm_q[r] & (|status_d[r]));
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Register access

	logic wr_mask_a;
	logic wr_mask_b;
	logic wr_mask_c;
	assign wr_mask_a = wr_en_in && (cmd_in == ctso_pkg::ADDR_MASK_A);
	assign wr_mask_b = wr_en_in && (cmd_in == ctso_pkg::ADDR_MASK_B);
	assign wr_mask_c = wr_en_in && (cmd_in == ctso_pkg::ADDR_MASK_C);
	assign mask_d[ctso_pkg::REG_A] = wr_mask_a ? wr_data_in[CH_N-1:0] : mask_q[ctso_pkg::REG_A];
	assign mask_d[ctso_pkg::REG_B] = wr_mask_b ? wr_data_in[CH_N-1:0] : mask_q[ctso_pkg::REG_B];
	assign mask_d[ctso_pkg::REG_C] = wr_mask_c ? wr_data_in[CH_N-1:0] : mask_q[ctso_pkg::REG_C];

	logic [ctso_pkg::DATA_W-1:0] common_w;
	assign common_w = (8'(|status_q[ctso_pkg::REG_A]) << ctso_pkg::FLAG_A_POS) |
		(8'(|status_q[ctso_pkg::REG_B]) << ctso_pkg::FLAG_B_POS) |
		(8'(|status_q[ctso_pkg::REG_C]) << ctso_pkg::FLAG_C_POS);

	// Unused upper bits read zero on every register
	assign rd_data_d = (cmd_in == ctso_pkg::ADDR_COMMON) ? common_w :
		(cmd_in == ctso_pkg::ADDR_STAT_A) ? {3'h0, status_q[ctso_pkg::REG_A]} :
		(cmd_in == ctso_pkg::ADDR_STAT_B) ? {3'h0, status_q[ctso_pkg::REG_B]} :
		(cmd_in == ctso_pkg::ADDR_STAT_C) ? {3'h0, status_q[ctso_pkg::REG_C]} :
		(cmd_in == ctso_pkg::ADDR_MASK_A) ? {3'h0, mask_q[ctso_pkg::REG_A]} :
		(cmd_in == ctso_pkg::ADDR_MASK_B) ? {3'h0, mask_q[ctso_pkg::REG_B]} :
		(cmd_in == ctso_pkg::ADDR_MASK_C) ? {3'h0, mask_q[ctso_pkg::REG_C]} : 8'h00;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			status_q <= '0;
			alarm_q <= '0;
			rd_data_out <= 8'h00;
			mask_q[ctso_pkg::REG_A] <= ctso_pkg::MASK_A_RST;
			mask_q[ctso_pkg::REG_B] <= ctso_pkg::MASK_B_RST;
			mask_q[ctso_pkg::REG_C] <= ctso_pkg::MASK_C_RST;
		end else begin
			status_q <= status_d;
			alarm_q <= alarm_d;
			mask_q <= mask_d;
			if (rd_en_in) begin
				rd_data_out <= rd_data_d;
			end
		end
	end

	// Pins are driven low while their alarm is active
	assign alarm_out_a_n_out = ~alarm_q[ctso_pkg::REG_A];
	assign alarm_out_b_n_out = ~alarm_q[ctso_pkg::REG_B];
	assign alarm_out_c_n_out = ~alarm_q[ctso_pkg::REG_C];

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	logic signed [EXT_W-1:0] loc_x;
	logic signed [EXT_W-1:0] loc_lim_x;
	logic signed [EXT_W-1:0] r1_x;
	logic signed [EXT_W-1:0] r1_lim_b_x;
	logic signed [EXT_W-1:0] r1_lim_a_x;
	logic signed [EXT_W-1:0] r2_x;
	logic signed [EXT_W-1:0] r2_lim_a_x;
	logic signed [EXT_W-1:0] r2_lim_b_x;
	logic signed [EXT_W-1:0] r3_x;
	logic signed [EXT_W-1:0] r3_lim_x;
	logic signed [EXT_W-1:0] hyst_x;
	logic loc_in_band;
	assign loc_x = {{2{local_temp_in[TEMP_W-1]}}, local_temp_in};
	assign loc_lim_x = {{2{local_limit_in[TEMP_W-1]}}, local_limit_in};
	assign r1_x = {{2{rem1_temp_in[TEMP_W-1]}}, rem1_temp_in};
	assign r1_lim_b_x = {{2{rem1_limit_b_in[TEMP_W-1]}}, rem1_limit_b_in};
	assign r1_lim_a_x = {{2{rem1_limit_a_in[TEMP_W-1]}}, rem1_limit_a_in};
	assign r2_x = {{2{rem2_temp_in[TEMP_W-1]}}, rem2_temp_in};
	assign r2_lim_a_x = {{2{rem2_limit_a_in[TEMP_W-1]}}, rem2_limit_a_in};
	assign r2_lim_b_x = {{2{rem2_limit_b_in[TEMP_W-1]}}, rem2_limit_b_in};
	assign r3_x = {{2{rem3_temp_in[TEMP_W-1]}}, rem3_temp_in};
	assign r3_lim_x = {{2{rem3_limit_in[TEMP_W-1]}}, rem3_limit_in};
	assign hyst_x = $signed({2'b00, hyst_in});
	assign loc_in_band = (loc_x < loc_lim_x) && (loc_x >= loc_lim_x - hyst_x);

	chk_alarm_a_active: assert property ((|(status_q[0] & ~mask_q[0])) |-> !alarm_out_a_n_out)
		else $error("alarm A not low with unmasked bit set");
	chk_alarm_a_release: assert property ((status_q[0] == '0) |-> alarm_out_a_n_out)
		else $error("alarm A low with all bits clear");
	chk_alarm_b_active: assert property ((|(status_q[1] & ~mask_q[1])) |-> !alarm_out_b_n_out)
		else $error("alarm B not low with unmasked bit set");
	chk_alarm_b_hold: assert property ((!alarm_out_b_n_out && (|status_d[1])) |=> !alarm_out_b_n_out)
		else $error("alarm B released while bits remain");
	chk_alarm_c_active: assert property ((|(status_q[2] & ~mask_q[2])) |-> !alarm_out_c_n_out)
		else $error("alarm C not low with unmasked bit set");
	chk_alarm_c_release: assert property ((status_q[2] == '0) |-> alarm_out_c_n_out)
		else $error("alarm C low with all bits clear");
	chk_reserved_zero: assert property ((rd_en_in && (cmd_in inside {8'h08, 8'h09, 8'h0a})) |=>
		(rd_data_out[7:5] == 3'h0 && rd_data_out[4:0] == $past(status_q[cmd_in - 8'h08]))) else $error("status read wrong");
	chk_local_set: assert property ((result_valid_in[0] && loc_x >= loc_lim_x) |=>
		(status_q[0][0] && status_q[1][0] && status_q[2][0])) else $error("local bits not set at limit");
	chk_rem1_clear: assert property ((result_valid_in[1] && r1_x < r1_lim_b_x - $signed({2'b00, hyst_in})) |=>
		(!status_q[1][1] && !status_q[2][1])) else $error("remote 1 bits not cleared below band");
	chk_hold_idle: assert property ((!result_valid_in[2]) |=> $stable({status_q[0][2], status_q[1][2], status_q[2][2]}))
		else $error("remote 2 bits changed without a result");
	chk_summary_flags: assert property (rd_en_in && cmd_in == 8'h02 |=> rd_data_out ==
		{4'h0, |$past(status_q[2]), |$past(status_q[1]), |$past(status_q[0]), 1'b0}) else $error("summary flags wrong");

	cov_alarm_a: cover property (!alarm_out_a_n_out ##1 alarm_out_a_n_out);
	cov_alarm_c: cover property (!alarm_out_c_n_out);
	cov_band_hold: cover property (result_valid_in[0] && status_q[0][0] && loc_x < loc_lim_x ##1 status_q[0][0]);
	cov_masked_hold: cover property (!alarm_out_c_n_out && ((status_q[2] & ~mask_q[2]) == '0));
	cov_rw_same: cover property (rd_en_in && wr_en_in);

	chk_alarm_a_hold: assert property ((!alarm_out_a_n_out && (|status_d[0])) |=> !alarm_out_a_n_out)
		else $error("alarm A released while bits remain");
	chk_alarm_b_release: assert property ((status_q[1] == '0) |-> alarm_out_b_n_out)
		else $error("alarm B low with all bits clear");
	chk_alarm_c_hold: assert property ((!alarm_out_c_n_out && (|status_d[2])) |=> !alarm_out_c_n_out)
		else $error("alarm C released while bits remain");
	chk_mask_block: assert property ((alarm_out_a_n_out && !(|(status_d[0] & ~mask_d[0]))) |=>
		alarm_out_a_n_out) else $error("masked event reached alarm A");
	chk_rem1_limit_a: assert property ((result_valid_in[1] && r1_x >= r1_lim_a_x) |=> status_q[0][1])
		else $error("remote 1 first-level bit not set");
	chk_rem2_limit_a: assert property ((result_valid_in[2] && r2_x >= r2_lim_a_x) |=> status_q[0][2])
		else $error("remote 2 first-level bit not set");
	chk_rem1_limit_b: assert property ((result_valid_in[1] && r1_x >= r1_lim_b_x) |=> status_q[1][1])
		else $error("remote 1 second-level bit not set");
	chk_rem2_limit_c: assert property ((result_valid_in[2] && r2_x >= r2_lim_b_x) |=>
		(status_q[1][2] && status_q[2][2])) else $error("remote 2 bits B and C not set");
	chk_rem3_shared: assert property ((result_valid_in[3] && r3_x >= r3_lim_x) |=>
		(status_q[0][3] && status_q[1][3] && status_q[2][3])) else $error("remote 3 bits not set everywhere");
	chk_local_clear: assert property ((result_valid_in[0] && loc_x < loc_lim_x - hyst_x) |=>
		(!status_q[0][0] && !status_q[1][0] && !status_q[2][0])) else $error("local bits not cleared below band");
	chk_band_hold: assert property ((result_valid_in[0] && loc_in_band) |=> $stable(status_q[0][0]))
		else $error("local bit changed inside band");
	chk_rem4_bit_map: assert property ((result_valid_in == 5'h10) |=>
		($stable(status_q[0][3:0]) && $stable(status_q[1][3:0]) && $stable(status_q[2][3:0])))
		else $error("remote 4 result touched other bits");
	chk_mask_reserved: assert property ((rd_en_in && (cmd_in inside {8'h0c, 8'h0d, 8'h0e})) |=>
		(rd_data_out[7:5] == 3'h0)) else $error("mask read reserved bits not zero");
endmodule : ctso_crit_status

// file: verification/ctso_shutdown_model.sv
`timescale 1ns/1ps
module ctso_shutdown_model (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [2:0] alarm_n_in,
	output logic trip_out
);
	// Shutdown logic latches once any alarm pin has been pulled low
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			trip_out <= 1'b0;
		end else if (alarm_n_in != 3'h7) begin
			trip_out <= 1'b1;
		end
	end
endmodule : ctso_shutdown_model

// file: verification/tb_crit_temp_status_outputs.sv
`timescale 1ns/1ps
module tb_crit_temp_status_outputs;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] vld = 5'h00;
	logic signed [10:0] t [5] = '{default: 11'sh000};
	logic signed [10:0] lim [7] = '{11'sh064, 11'sh032, 11'sh03c, 11'sh032, 11'sh03c, 11'sh046, 11'sh050};
	logic [10:0] hyst = 11'h00a;
	logic [7:0] cmd = 8'h00;
	logic [7:0] wd = 8'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [7:0] rdat;
	logic [2:0] pin;
	logic trip;
	int fail_count = 0;
	int compares = 0;
	int cyc = 0;
	always #2.5 clk = ~clk;
	ctso_crit_status i_dut (.clk_in(clk), .reset_in(rst), .result_valid_in(vld), .local_temp_in(t[0]),
		.rem1_temp_in(t[1]), .rem2_temp_in(t[2]), .rem3_temp_in(t[3]), .rem4_temp_in(t[4]),
		.local_limit_in(lim[0]), .rem1_limit_a_in(lim[1]), .rem1_limit_b_in(lim[2]), .rem2_limit_a_in(lim[3]),
		.rem2_limit_b_in(lim[4]), .rem3_limit_in(lim[5]), .rem4_limit_in(lim[6]), .hyst_in(hyst),
		.cmd_in(cmd), .rd_en_in(rd_en), .wr_en_in(wr_en), .wr_data_in(wd), .rd_data_out(rdat),
		.alarm_out_a_n_out(pin[2]), .alarm_out_b_n_out(pin[1]), .alarm_out_c_n_out(pin[0]));
	ctso_shutdown_model i_far (.clk_in(clk), .reset_in(rst), .alarm_n_in(pin), .trip_out(trip));
	////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (fail_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		cmd = a;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		@(negedge clk);
		chk(rdat, exp);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cmd = a;
		wd = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
	endtask : wr
	task automatic conv(input int c, input logic signed [10:0] v);
		t[c] = v;
		vld[c] = 1'b1;
		@(negedge clk);
		vld = 5'h00;
		@(negedge clk);
	endtask : conv
	task automatic pins(input logic [2:0] e);
		chk({5'h00, pin}, {5'h00, e});
	endtask : pins
	////////////////////////////////////////////////////////////////
	task automatic reset_vals;
		rd(8'h0c, 8'h19);
		rd(8'h0d, 8'h00);
		rd(8'h0e, 8'h07);
		rd(8'h08, 8'h00);
		rd(8'h44, 8'h00);
		pins(3'h7);
	endtask : reset_vals
	task automatic limit_sel;
		conv(1, 11'sh037);
		rd(8'h08, 8'h02);
		rd(8'h09, 8'h00);
		conv(1, 11'sh03c);
		rd(8'h0a, 8'h02);
		rd(8'h02, 8'h0e);
		pins(3'h1);
	endtask : limit_sel
	task automatic hyst_band;
		conv(1, 11'sh02d);
		rd(8'h08, 8'h02);
		rd(8'h09, 8'h00);
		pins(3'h3);
		conv(1, 11'sh027);
		rd(8'h08, 8'h00);
		pins(3'h7);
	endtask : hyst_band
	task automatic other_ch;
		t[4] = 11'sh050;
		@(negedge clk);
		rd(8'h09, 8'h00);
		conv(0, 11'sh064);
		rd(8'h09, 8'h01);
		pins(3'h5);
		conv(3, 11'sh046);
		conv(4, 11'sh050);
		rd(8'h08, 8'h19);
		pins(3'h4);
		wr(8'h0e, 8'hff);
		rd(8'h0e, 8'h1f);
		wr(8'h0a, 8'h00);
		conv(0, 11'sh000);
		conv(3, 11'sh000);
		rd(8'h0a, 8'h10);
		pins(3'h4);
		conv(4, 11'sh000);
		pins(3'h7);
	endtask : other_ch
	task automatic mid_reset;
		conv(0, 11'sh064);
		pins(3'h5);
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		reset_vals;
	endtask : mid_reset
	task automatic mask_rem2;
		wr(8'h0c, 8'h00);
		rd(8'h0c, 8'h00);
		conv(2, 11'sh032);
		rd(8'h08, 8'h04);
		rd(8'h09, 8'h00);
		pins(3'h3);
		conv(2, 11'sh03c);
		rd(8'h0a, 8'h04);
		pins(3'h1);
		conv(0, 11'sh05f);
		rd(8'h09, 8'h04);
		conv(2, 11'sh000);
		pins(3'h7);
		cmd = 8'h0d;
		wd = 8'h1f;
		wr_en = 1'b1;
		rd_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
		rd_en = 1'b0;
		@(negedge clk);
		chk(rdat, 8'h00);
		rd(8'h0d, 8'h1f);
	endtask : mask_rem2
	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			fail_count++;
			end_sim;
		end
	end
	initial begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		reset_vals;
		limit_sel;
		hyst_band;
		other_ch;
		mid_reset;
		mask_rem2;
		chk({7'h00, trip}, 8'h01);
		end_sim;
	end
endmodule : tb_crit_temp_status_outputs
